// ===== hw/adcseq_pkg.sv
// Shared constants and types of the converter acquisition sequencer
package adcseq_pkg;
  // ------------------------------------------------------------
  // Register offsets and fields
  // ------------------------------------------------------------
  localparam logic [15:0] ASYNC_SETUP_OFS = 16'h0ff5;
  localparam logic [15:0] IO_STATUS_OFS = 16'h0ff6;
  localparam logic [15:0] ASP_CFG_WORD = 16'h0000;
  localparam logic [15:0] ASP_ACT_WORD = 16'h2000;
  localparam logic [15:0] ASP_WR_MASK = 16'h23ff;
  localparam logic [15:0] ASP_RESET = 16'h0000;
  localparam int ASP_RUN_BIT = 13;
  localparam int ASP_DIM_BIT = 9;
  localparam int IOS_TX_EMPTY_BIT = 12;
  localparam int IOS_TX_HOLDING_EMPTY_BIT = 11;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] SP_CFG_WORD = 16'h000c;
  localparam logic [15:0] SP_RUN_WORD = 16'h003c;
  localparam int SP_RUN_BIT = 4;
  localparam logic [2:0] WAIT_ZERO = 3'h0;
  // ------------------------------------------------------------
  // Frame and sequencing counts
  // ------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] LAST_BIT = 5'h0f;
  localparam logic [1:0] VALID_RX_WORD_IRQ = 2'h2;
  localparam int LINK_DIV = 2;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic fast;
    logic [3:0] chan;
    logic [15:0] count;
    logic [15:0] addr;
  } adcseq_cfg_t;
  typedef struct packed {
    logic we;
    logic [15:0] addr;
    logic [15:0] data;
  } adcseq_mem_t;
endpackage

// ===== hw/adcseq_top.sv
// Acquisition sequencer, register file and serial frame engine
`timescale 1ns/1ps
// How it works
// - Configure writes zero, activate sets only bit 13; bit 13 low holds reset.
// - All four pin direction bits are cleared, so pins stay inputs.
// - Status register: bits 15..13 zero, port status 12..8, change flags, levels.
// - A level change on input 3 sets its flag, then a delta request if enabled.
// - Change flag stays set until cleared; sequencer clears it per delta request.
// - Inverted end-of-conversion enters input 3 as completion event source.
// - Serial transfer clock runs at half the core link clock rate.
// - Chip select goes low before the control word is loaded.
// - Each frame shifts a control word out while the result shifts in.
// - Receive event comes on the 16th transfer clock after frame sync low.
// - On receive event drop chip select, store word, then idle.
// - On end-of-conversion reassert chip select and load the next word.
// - Converter enabled at run start, disabled at end; no test or sleep words.
// - A run stores exactly the requested samples from the start address.
// - Conversion mode word is selectable between fast and slow.
// - Initialization disables interrupts and sets zero wait states.
// - Sync port in burst mode, internal frame sync and clock, activated before the async port.
// - Received words count as valid only from the third receive event.
// - First frame sends the mode word, later frames the channel word.
module adcseq_top
  import adcseq_pkg::*;
#(
  parameter logic [15:0] MODE_FAST_WORD = 16'h0001,
  parameter logic [15:0] MODE_SLOW_WORD = 16'h0002,
  parameter int NUM_CHAN = 4
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic clk_link_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_wdata_i,
  output logic [15:0] io_rdata_o,
  input wire logic [3:0] gp_pins_i,
  output logic [3:0] gp_pins_o,
  output logic [3:0] gp_pins_oe_o,
  input wire logic start_i,
  input wire adcseq_cfg_t cfg_i,
  output logic busy_o,
  output logic done_o,
  output adcseq_mem_t mem_o,
  output logic [2:0] wait_states_o,
  output logic [15:0] sync_port_setup_o,
  output logic conv_cs_n_o,
  output logic serial_tx_clock_o,
  output logic frame_sync_o,
  output logic serial_dout_o,
  input wire logic serial_din_i,
  output logic rx_word_irq_o,
  output logic delta_irq_o
);
  if (NUM_CHAN < 1 || NUM_CHAN > 16) begin : g_chk
    $error("NUM_CHAN must be 1 to 16");
  end

  // ------------------------------------------------------------
  // Reset release and synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_q;
  logic srst_n;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) rst_q <= 2'h0;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign srst_n = rst_q[1];

  typedef enum {S_IDLE, S_INIT, S_SP_ACT, S_ASP_CFG, S_ASP_ACT, S_CS_LOW, S_SEND,
                S_WAIT_RX, S_WAIT_EOC, S_DONE} adcseq_state_t;
  adcseq_state_t seq_q;
  adcseq_cfg_t cfg_q;
  logic [15:0] asp_q;
  logic [3:0] flag_q, gp_s1_q, gp_s2_q, gp_prev_q, gp_out_q;
  logic [15:0] status;
  logic port_run, seq_asp_wr, seq_dim_set, seq_dim_clr, seq_flag3_clr;
  logic asp_wr, ios_wr, rx_irq_en_q;
  logic [15:0] seq_asp_word;
  logic [2:0] done_s_q;
  logic rx_done_s;
  logic start_tgl_q, done_tgl_q;
  logic [15:0] tx_word_q, rx_word_q;
  logic [1:0] rx_word_irq_cnt_q;

  always_ff @(posedge clk_sys_i or negedge srst_n) begin
    if (!srst_n) begin
      gp_s1_q <= 4'h0;
      gp_s2_q <= 4'h0;
      gp_prev_q <= 4'h0;
      done_s_q <= 3'h0;
    end else begin
      gp_s1_q <= gp_pins_i;
      gp_s2_q <= gp_s1_q;
      gp_prev_q <= gp_s2_q;
      done_s_q <= {done_s_q[1:0], done_tgl_q};
    end
  end
  assign rx_done_s = done_s_q[2] ^ done_s_q[1];

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  assign port_run = asp_q[ASP_RUN_BIT];
  assign asp_wr = io_wr_i && (io_addr_i == ASYNC_SETUP_OFS);
  assign ios_wr = io_wr_i && (io_addr_i == IO_STATUS_OFS);
  assign status = {3'h0, port_run, port_run, 3'h0, flag_q & {4{port_run}}, gp_s2_q};

  always_ff @(posedge clk_sys_i or negedge srst_n) begin
    if (!srst_n) asp_q <= ASP_RESET;
    else if (seq_asp_wr) asp_q <= seq_asp_word;
    else if (seq_dim_set) asp_q[ASP_DIM_BIT] <= 1'b1;
    else if (seq_dim_clr) asp_q[ASP_DIM_BIT] <= 1'b0;
    else if (asp_wr) asp_q <= io_wdata_i & ASP_WR_MASK;
  end

  always_ff @(posedge clk_sys_i or negedge srst_n) begin
    if (!srst_n) gp_out_q <= 4'h0;
    else if (ios_wr) gp_out_q <= io_wdata_i[3:0];
  end
  assign gp_pins_o = gp_out_q;
  assign gp_pins_oe_o = asp_q[3:0] & {4{port_run}};

  always_ff @(posedge clk_sys_i or negedge srst_n) begin
    if (!srst_n) io_rdata_o <= 16'h0000;
    else if (io_rd_i && io_addr_i == ASYNC_SETUP_OFS) io_rdata_o <= asp_q;
    else if (io_rd_i && io_addr_i == IO_STATUS_OFS) io_rdata_o <= status;
    else io_rdata_o <= 16'h0000;
  end

  // ------------------------------------------------------------
  // Pin change flags
  // ------------------------------------------------------------
  logic [3:0] flag_d;
  for (genvar i = 0; i < 4; i++) begin : g_flag
    logic edge_seen, clr;
    assign edge_seen = (gp_s2_q[i] ^ gp_prev_q[i]) && !asp_q[i];
    assign clr = (ios_wr && io_wdata_i[4+i]) || (i == 3 && seq_flag3_clr);
    assign flag_d[i] = port_run && (edge_seen || (flag_q[i] && !clr));
  end
  always_ff @(posedge clk_sys_i or negedge srst_n) begin
    if (!srst_n) flag_q <= 4'h0;
    else flag_q <= flag_d;
  end
  assign delta_irq_o = flag_q[3] && asp_q[ASP_DIM_BIT] && port_run;
  assign rx_word_irq_o = rx_done_s && rx_irq_en_q;

  // ------------------------------------------------------------
  // Acquisition sequencer
  // ------------------------------------------------------------
  logic [15:0] chan_word, mode_word;
  logic valid_rx, last_rx;
  assign chan_word = {((int'(cfg_q.chan) < NUM_CHAN) ? cfg_q.chan : 4'h0), 12'h000};
  assign mode_word = cfg_q.fast ? MODE_FAST_WORD : MODE_SLOW_WORD;
  assign valid_rx = (rx_word_irq_cnt_q >= VALID_RX_WORD_IRQ);
  assign last_rx = valid_rx && (cfg_q.count == 16'h0001);
  assign seq_asp_wr = (seq_q == S_ASP_CFG) || (seq_q == S_ASP_ACT);
  assign seq_asp_word = (seq_q == S_ASP_CFG) ? ASP_CFG_WORD : ASP_ACT_WORD;
  assign seq_dim_set = (seq_q == S_WAIT_RX) && rx_done_s && !last_rx;
  assign seq_dim_clr = ((seq_q == S_WAIT_EOC) && delta_irq_o) || (seq_q == S_DONE);
  assign seq_flag3_clr = seq_dim_set || ((seq_q == S_WAIT_EOC) && delta_irq_o);
  assign busy_o = (seq_q != S_IDLE);

  always_ff @(posedge clk_sys_i or negedge srst_n) begin
    if (!srst_n) begin
      seq_q <= S_IDLE;
      cfg_q <= '0;
      conv_cs_n_o <= 1'b1;
      done_o <= 1'b0;
      mem_o <= '0;
      wait_states_o <= WAIT_ZERO;
      sync_port_setup_o <= SP_RESET;
      rx_irq_en_q <= 1'b0;
      start_tgl_q <= 1'b0;
      tx_word_q <= 16'h0000;
      rx_word_irq_cnt_q <= 2'h0;
    end else begin
      done_o <= 1'b0;
      mem_o.we <= 1'b0;
      unique case (seq_q)
        S_IDLE: if (start_i) begin
          cfg_q <= cfg_i;
          seq_q <= S_INIT;
        end
        S_INIT: begin
          rx_irq_en_q <= 1'b0;
          wait_states_o <= WAIT_ZERO;
          sync_port_setup_o <= SP_CFG_WORD;
          seq_q <= S_SP_ACT;
        end
        S_SP_ACT: begin
          sync_port_setup_o <= SP_RUN_WORD;
          seq_q <= S_ASP_CFG;
        end
        S_ASP_CFG: seq_q <= S_ASP_ACT;
        S_ASP_ACT: begin
          rx_word_irq_cnt_q <= 2'h0;
          rx_irq_en_q <= 1'b1;
          tx_word_q <= mode_word;
          seq_q <= (cfg_q.count == 16'h0000) ? S_DONE : S_CS_LOW;
        end
        S_CS_LOW: begin
          conv_cs_n_o <= 1'b0;
          seq_q <= S_SEND;
        end
        S_SEND: begin
          start_tgl_q <= ~start_tgl_q;
          seq_q <= S_WAIT_RX;
        end
        S_WAIT_RX: if (rx_done_s) begin
          conv_cs_n_o <= 1'b1;
          tx_word_q <= chan_word;
          if (!valid_rx) rx_word_irq_cnt_q <= rx_word_irq_cnt_q + 2'h1;
          if (valid_rx) begin
            mem_o.we <= 1'b1;
            mem_o.addr <= cfg_q.addr;
            mem_o.data <= rx_word_q;
            cfg_q.addr <= cfg_q.addr + 16'h0001;
            cfg_q.count <= cfg_q.count - 16'h0001;
          end
          seq_q <= last_rx ? S_DONE : S_WAIT_EOC;
        end
        S_WAIT_EOC: if (delta_irq_o) seq_q <= S_CS_LOW;
        S_DONE: begin
          rx_irq_en_q <= 1'b0;
          conv_cs_n_o <= 1'b1;
          done_o <= 1'b1;
          seq_q <= S_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Link domain frame engine
  // ------------------------------------------------------------
  typedef enum {L_IDLE, L_FS, L_LOAD, L_SHIFT} adcseq_link_t;
  adcseq_link_t lk_q;
  logic [1:0] lrst_q;
  logic lrst_n, sclk_q, start_edge;
  logic [2:0] start_s_q;
  logic [1:0] run_s_q, din_s_q;
  logic [15:0] txsr_q, rxsr_q;
  logic [4:0] bit_q;

  always_ff @(posedge clk_link_i or negedge rstn_i) begin
    if (!rstn_i) lrst_q <= 2'h0;
    else lrst_q <= {lrst_q[0], 1'b1};
  end
  assign lrst_n = lrst_q[1];
  assign start_edge = start_s_q[2] ^ start_s_q[1];

  always_ff @(posedge clk_link_i or negedge lrst_n) begin
    if (!lrst_n) begin
      start_s_q <= 3'h0;
      run_s_q <= 2'h0;
      din_s_q <= 2'h0;
      sclk_q <= 1'b0;
    end else begin
      start_s_q <= {start_s_q[1:0], start_tgl_q};
      run_s_q <= {run_s_q[0], sync_port_setup_o[SP_RUN_BIT]};
      din_s_q <= {din_s_q[0], serial_din_i};
      sclk_q <= ~sclk_q;
    end
  end
  assign serial_tx_clock_o = sclk_q;

  always_ff @(posedge clk_link_i or negedge lrst_n) begin
    if (!lrst_n) begin
      lk_q <= L_IDLE;
      frame_sync_o <= 1'b0;
      serial_dout_o <= 1'b0;
      txsr_q <= 16'h0000;
      rxsr_q <= 16'h0000;
      rx_word_q <= 16'h0000;
      bit_q <= 5'h00;
      done_tgl_q <= 1'b0;
    end else if (!run_s_q[1]) begin
      lk_q <= L_IDLE;
      frame_sync_o <= 1'b0;
    end else begin
      unique case (lk_q)
        L_IDLE: if (start_edge) lk_q <= L_FS;
        L_FS: if (!sclk_q) begin
          frame_sync_o <= 1'b1;
          lk_q <= L_LOAD;
        end
        L_LOAD: if (!sclk_q) begin
          frame_sync_o <= 1'b0;
          serial_dout_o <= tx_word_q[15];
          txsr_q <= {tx_word_q[14:0], 1'b0};
          bit_q <= 5'h00;
          lk_q <= L_SHIFT;
        end
        L_SHIFT: if (!sclk_q) begin
          serial_dout_o <= txsr_q[15];
          txsr_q <= {txsr_q[14:0], 1'b0};
        end else begin
          rxsr_q <= {rxsr_q[14:0], din_s_q[1]};
          bit_q <= bit_q + 5'h01;
          if (bit_q == LAST_BIT) begin
            rx_word_q <= {rxsr_q[14:0], din_s_q[1]};
            done_tgl_q <= ~done_tgl_q;
            lk_q <= L_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_cs_before_load: assert property (@(posedge clk_sys_i) disable iff (!srst_n)
    (seq_q == S_SEND) |-> (!conv_cs_n_o && $past(seq_q) == S_CS_LOW))
    else $error("frame started without chip select low first");
  a_flag_set: assert property (@(posedge clk_sys_i) disable iff (!srst_n)
    (port_run && !asp_q[3] && (gp_s2_q[3] != gp_prev_q[3])) |=> flag_q[3])
    else $error("pin 3 change did not set its flag");
  a_flag_hold: assert property (@(posedge clk_sys_i) disable iff (!srst_n)
    (flag_q[3] && port_run && !seq_flag3_clr && !(ios_wr && io_wdata_i[7])) |=> flag_q[3])
    else $error("pin 3 flag dropped without a clear");
  a_port_reset: assert property (@(posedge clk_sys_i) disable iff (!srst_n)
    !port_run |-> (status[14:4] == 11'h000))
    else $error("port status active while port held in reset");
  a_act_after_cfg: assert property (@(posedge clk_sys_i) disable iff (!srst_n)
    (seq_q == S_ASP_ACT) |=> (asp_q == ASP_ACT_WORD && $past(asp_q) == ASP_CFG_WORD))
    else $error("port activate write not preceded by configure write");
  a_pins_input: assert property (@(posedge clk_sys_i) disable iff (!srst_n)
    (seq_q == S_WAIT_EOC) |-> (gp_pins_oe_o == 4'h0))
    else $error("pin driven while waiting for end of conversion");
  a_rx_16th: assert property (@(posedge clk_link_i) disable iff (!lrst_n)
    (done_tgl_q != $past(done_tgl_q)) |-> ($past(bit_q) == LAST_BIT && $past(sclk_q)))
    else $error("receive word not complete on 16th clock");
  a_clk_half: assert property (@(posedge clk_link_i) disable iff (!lrst_n)
    sclk_q |=> !sclk_q ##1 sclk_q)
    else $error("transfer clock not at half rate");
  a_store_valid: assert property (@(posedge clk_sys_i) disable iff (!srst_n)
    mem_o.we |-> ($past(rx_word_irq_cnt_q) == VALID_RX_WORD_IRQ && conv_cs_n_o))
    else $error("sample stored before valid data");
  a_run_end: assert property (@(posedge clk_sys_i) disable iff (!srst_n)
    done_o |-> (conv_cs_n_o && !rx_irq_en_q && !asp_q[ASP_DIM_BIT] && !busy_o))
    else $error("run ended with converter or interrupts still enabled");
endmodule

// ===== bench/adcseq_conv_model.sv
// Serial converter model with inverted end-of-conversion output
`timescale 1ns/1ps
module adcseq_conv_model (
  input wire logic clk_link_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic fs_i,
  input wire logic dout_i,
  input wire logic [9:0] sample_i,
  input wire logic [7:0] conv_wait_i,
  output logic din_o,
  output logic eoc_n_o,
  output logic stb_o,
  output logic [15:0] ctl_o,
  output logic [15:0] txw_o,
  output logic [7:0] err_o
);
  // ----------------------------------------
  // Frame shifting and conversion timing
  // ----------------------------------------
  logic act;
  logic [4:0] nr;
  logic [4:0] nf;
  logic [15:0] sh;
  logic [15:0] res;
  logic [7:0] wt;
  always @(posedge clk_link_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {act, nr, nf, sh, res, wt, din_o, eoc_n_o, stb_o} <= '0;
      {ctl_o, txw_o, err_o} <= '0;
    end else begin
      stb_o <= 1'b0;
      if (wt != 8'h00) begin
        wt <= wt - 8'h01;
        if (wt == 8'h01) eoc_n_o <= 1'b0; // Conversion ends
      end
      if (!sclk_i && fs_i) begin // Old result goes out as control comes
        act <= 1'b1;
        nr <= 5'h02;
        nf <= 5'h00;
        din_o <= res[14];
        sh <= res;
        txw_o <= res;
        if (cs_n_i) err_o <= err_o + 8'h01;
      end else if (!sclk_i && act && nr < 5'h10) begin
        din_o <= sh[4'hf - nr[3:0]];
        nr <= nr + 5'h01;
      end else if (!act && !cs_n_i) begin
        din_o <= res[15]; // MSB presented from chip select low
      end else if (!sclk_i && !act) begin
        din_o <= ~din_o;
      end
      if (sclk_i && act) begin
        ctl_o <= {ctl_o[14:0], dout_i};
        nf <= nf + 5'h01;
        if (cs_n_i) err_o <= err_o + 8'h01;
        if (nf == 5'h09) eoc_n_o <= 1'b1; // Busy converting, inverted line
        if (nf == 5'h0f) begin
          act <= 1'b0;
          stb_o <= 1'b1;
          res <= {6'h00, sample_i};
          wt <= conv_wait_i;
        end
      end
    end
  end
endmodule

// ===== bench/test_adc_serial_acquisition_sequencer.sv
// Self-checking bench of the acquisition sequencer
`timescale 1ns/1ps
module test_adc_serial_acquisition_sequencer;
  import adcseq_pkg::*;
  // ----------------------------------------
  // Stimulus and wiring
  // ----------------------------------------
  logic clk = 1'b0;
  logic clk_link = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [15:0] io_wdata = 16'h0000;
  logic [15:0] io_rdata;
  logic [2:0] gp_lo = 3'h5;
  logic start = 1'b0;
  adcseq_cfg_t cfg = '0;
  logic busy, done, cs_n, sclk, fs, dout, din, rx_irq, dl_irq, eoc_n, stb;
  adcseq_mem_t mem;
  logic [2:0] wait_st;
  logic [15:0] sp_setup, ctl, txw;
  logic [3:0] gp_oe, gp_out;
  logic [7:0] err, conv_wait = 8'h08;
  logic [9:0] smp = 10'h000;
  logic [31:0] lfsr = 32'h22f5;
  logic [15:0] ctlq[$], txq[$], mq[$], maq[$];
  int num_errors = 0;
  int num_checks = 0;
  int nrx;
  adcseq_top #(.MODE_FAST_WORD(16'h0001), .MODE_SLOW_WORD(16'h0002), .NUM_CHAN(4)) u_dut (
    .clk_sys_i(clk), .rstn_i(rstn), .clk_link_i(clk_link), .io_addr_i(io_addr),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .gp_pins_i({eoc_n, gp_lo}), .gp_pins_o(gp_out), .gp_pins_oe_o(gp_oe), .start_i(start),
    .cfg_i(cfg), .busy_o(busy), .done_o(done), .mem_o(mem), .wait_states_o(wait_st),
    .sync_port_setup_o(sp_setup), .conv_cs_n_o(cs_n), .serial_tx_clock_o(sclk),
    .frame_sync_o(fs), .serial_dout_o(dout), .serial_din_i(din), .rx_word_irq_o(rx_irq),
    .delta_irq_o(dl_irq));
  adcseq_conv_model u_conv (
    .clk_link_i(clk_link), .rstn_i(rstn), .cs_n_i(cs_n), .sclk_i(sclk), .fs_i(fs),
    .dout_i(dout), .sample_i(smp), .conv_wait_i(conv_wait), .din_o(din), .eoc_n_o(eoc_n),
    .stb_o(stb), .ctl_o(ctl), .txw_o(txw), .err_o(err));
  initial forever #20 clk = ~clk;
  initial begin
    #7;
    forever #62.5 clk_link = ~clk_link;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk) begin
    lfsr <= nxt(lfsr);
    smp <= lfsr[9:0];
  end
  always @(negedge clk_link) begin
    if (stb === 1'b1) begin
      ctlq.push_back(ctl);
      txq.push_back(txw);
    end
  end
  always @(negedge clk) begin
    if (mem.we === 1'b1) begin
      mq.push_back(mem.data);
      maq.push_back(mem.addr);
    end
    if (rx_irq === 1'b1) nrx++;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    @(negedge clk);
    chk(io_rdata, exp, what);
  endtask
  task automatic run(input adcseq_cfg_t c);
    int k;
    int n;
    logic [15:0] ch;
    repeat (150) @(posedge clk);
    ctlq.delete();
    txq.delete();
    mq.delete();
    maq.delete();
    nrx = 0;
    conv_wait <= c.fast ? 8'h08 : 8'h28;
    cfg <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 8000) begin
      @(negedge clk);
      k++;
      if (k == 20 && busy === 1'b1) begin
        chk(sp_setup, SP_RUN_WORD, "sync port");
        chk({13'h0, wait_st}, {13'h0, WAIT_ZERO}, "wait states");
        chk({12'h0, gp_oe}, 16'h0000, "pins input");
      end
    end
    chk({15'h0, done}, 16'h0001, "done");
    repeat (2) @(negedge clk);
    chk({13'h0, cs_n, dl_irq, busy}, 16'h0004, "end state");
    n = (c.count == 16'h0) ? 0 : int'(c.count) + 2;
    ch = (c.chan < 4'h4) ? {c.chan, 12'h000} : 16'h0000;
    chk(16'(ctlq.size()), 16'(n), "frames");
    chk(16'(nrx), 16'(n), "rx events");
    chk({8'h00, err}, 16'h0000, "select framing");
    for (int i = 0; i < ctlq.size(); i++) begin
      chk(ctlq[i], (i > 0) ? ch : (c.fast ? 16'h0001 : 16'h0002), "control");
    end
    chk(16'(mq.size()), c.count, "samples");
    for (int i = 0; i < mq.size() && i + 2 < txq.size(); i++) begin
      chk(maq[i], c.addr + 16'(i), "addr");
      chk(mq[i], txq[i + 2], "data");
    end
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    $display("[ERR] %0t watchdog", $time);
    complete_run();
  end
  initial begin
    adcseq_cfg_t c;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(ASYNC_SETUP_OFS, ASP_RESET, "asp reset");
    rd(IO_STATUS_OFS, 16'h0005, "status reset");
    rd(16'h0123, 16'h0000, "unmapped");
    wr(ASYNC_SETUP_OFS, 16'hdfff);
    rd(ASYNC_SETUP_OFS, 16'h03ff, "asp mask");
    chk({12'h0, gp_oe}, 16'h0000, "held reset");
    wr(ASYNC_SETUP_OFS, 16'hffff);
    @(negedge clk);
    chk({12'h0, gp_oe}, 16'h000f, "outputs");
    wr(ASYNC_SETUP_OFS, ASP_CFG_WORD);
    wr(ASYNC_SETUP_OFS, ASP_ACT_WORD);
    rd(ASYNC_SETUP_OFS, ASP_ACT_WORD, "asp act");
    rd(IO_STATUS_OFS, 16'h1805, "status run");
    @(posedge clk);
    gp_lo <= 3'h7;
    repeat (6) @(posedge clk);
    rd(IO_STATUS_OFS, 16'h1827, "flag set");
    repeat (20) @(posedge clk);
    rd(IO_STATUS_OFS, 16'h1827, "flag held");
    wr(IO_STATUS_OFS, 16'h0020);
    rd(IO_STATUS_OFS, 16'h1807, "flag clear");
    wr(IO_STATUS_OFS, 16'h000a);
    @(negedge clk);
    chk({12'h0, gp_out}, 16'h000a, "pin levels");
    for (int i = 0; i < 6; i++) begin
      c.fast = i[0];
      c.chan = (i == 2) ? 4'h3 : lfsr[11:8];
      c.count = (i == 1) ? 16'h0000 : {13'h0, lfsr[6:4]} + 16'h0001;
      c.addr = lfsr[31:16];
      run(c);
    end
    complete_run();
  end
endmodule
